// [core/meg_pkg.sv]
// constants and types shared by the envelope generator
package meg_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS        = 4;      // core_clk period, ns
  localparam int STEP_UNIT_NS  = 10240;  // base time unit of one step
  localparam int STEP_UNIT_CYC = STEP_UNIT_NS / CLK_NS;

  // ---------------------------------------------------------------
  // level scale and key tracking
  // ---------------------------------------------------------------
  localparam logic [6:0]  LVL_MAX    = 7'h63;  // 99
  localparam logic [6:0]  KEY_CENTER = 7'h3c;  // tracking pivot key
  localparam logic [7:0]  TRK_SPAN   = 8'h18;  // two octaves
  localparam logic [8:0]  DIV99_MUL  = 9'h14b; // x/99 ~ x*331>>15
  localparam int          DIV99_SH   = 15;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_TIME0 = 4'h0;
  localparam logic [3:0] OFS_TIME1 = 4'h4;
  localparam logic [3:0] OFS_CTRL  = 4'h8;
  localparam logic [3:0] OFS_STAT  = 4'hc;

  // byte lanes of TIME0/TIME1/STAT, each field 7 bits wide except the 3-bit STAT stage
  localparam int FB0 = 0;
  localparam int FB1 = 8;
  localparam int FB2 = 16;
  localparam int FB3 = 24;
  // CTRL bit positions
  localparam int CB_TRIG  = 0;   // 2 bits
  localparam int CB_TTRK  = 2;
  localparam int CB_PEDAL = 3;
  localparam int CB_MONO  = 4;
  localparam int CB_MODS  = 5;
  localparam int CB_DEPTH = 8;   // 7 bits

  // reset values
  localparam logic [31:0] RST_TIME0 = 32'h6300_0000; // sustain 99
  localparam logic [31:0] RST_TIME1 = 32'h0063_0063; // sdec 99, lvl 99
  localparam logic [31:0] RST_CTRL  = 32'h0000_0000;

  typedef enum logic [1:0] {
    TRG_NORMAL, TRG_FREE, TRG_RESET, TRG_RESET_FREE
  } meg_trig_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DELAY, ST_ATTACK, ST_DECAY, ST_SUSTAIN, ST_RELEASE
  } meg_stage_t;

  typedef struct packed {
    logic       on;      // note-on pulse
    logic       off;     // note-off pulse
    logic       legato;  // note-on while another key is down
    logic [6:0] key;
    logic [6:0] vel;
  } meg_note_t;

  typedef struct packed {
    logic [6:0] dly;
    logic [6:0] atk;
    logic [6:0] dcy;
    logic [6:0] sus;
    logic [6:0] sdec;
    logic [6:0] rel;
    logic [6:0] lvl;
    logic [6:0] velAmt;
    meg_trig_t  trig;
    logic       timeTrk;
    logic       pedalEn;
    logic       mono;
    logic       modSel;
    logic [6:0] depth;
  } meg_cfg_t;

endpackage

// [core/meg_env.sv]
// multi-stage envelope generator for one voice
//
// Behaviour
// - velocity-to-level amount scales how much velocity raises output level
// - level setting plus velocity part saturates at 99
// - filter sees output only with nonzero depth or as mod source
// - attack rises to maximum; 0 is instant, 99 takes seconds
// - after attack maximum, decay falls toward sustain level
// - sustain level 99 skips decay entirely
// - key release, or pedal release holding note, starts release to zero
// - delay waits before attack; 0 starts attack at once
// - delay above 99 holds until key release, then continues
// - hold delay behaves as run-to-completion, stored mode unchanged
// - sustain-decay falls to 0; 99 holds, 0 drops at once
// - trigger mode has four values: normal, free, reset, reset-free
// - normal mode continues from current level; release is immediate
// - run-to-completion finishes the cycle despite early release
// - restart modes restart the cycle on every new note
// - mono legato retriggers only in restart modes
// - time tracking halves or doubles later stage times over two octaves
// - time tracking leaves attack time unchanged
// - pedal held, zero delay/attack, quick decay: release jumps to sustain
// - pedal held, release during attack jumps to sustain-decay
// - pedal held, release in delay keeps zero; free mode proceeds
// - pedal off ignores pedal; level 00 silent, 99 full
`timescale 1ns/100ps
`default_nettype none

module meg_env
  import meg_pkg::*;
#(
  parameter int TICK_CYC = STEP_UNIT_CYC
) (
  input  wire logic      core_clk,
  input  wire logic      rst_b,
  input  wire logic [3:0] regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic      regWr,
  input  wire logic      regRd,
  output logic     [31:0] regRdata,
  input  wire meg_note_t noteIn,
  input  wire logic      pedal,
  output logic     [6:0] envOut,
  output logic     [6:0] filterOut,
  output meg_stage_t     envStage
);

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  // step counter is 28 bits; 99*99*TICK_CYC*2 must fit
  if (TICK_CYC < 1 || TICK_CYC > 4095) begin : g_bad_tick
    $error("TICK_CYC out of range");
  end

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  meg_cfg_t   cfg_r;
  meg_stage_t stage_r;
  meg_stage_t stagePrev_r;
  logic [6:0] level_r;
  logic [6:0] envOut_r;
  logic [6:0] filterOut_r;
  logic [31:0] regRdata_r;

  // field-wise write; config steers every stage decision
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cfg_r.dly     <= RST_TIME0[FB0 +: 7];
      cfg_r.atk     <= RST_TIME0[FB1 +: 7];
      cfg_r.dcy     <= RST_TIME0[FB2 +: 7];
      cfg_r.sus     <= RST_TIME0[FB3 +: 7];
      cfg_r.sdec    <= RST_TIME1[FB0 +: 7];
      cfg_r.rel     <= RST_TIME1[FB1 +: 7];
      cfg_r.lvl     <= RST_TIME1[FB2 +: 7];
      cfg_r.velAmt  <= RST_TIME1[FB3 +: 7];
      cfg_r.trig    <= meg_trig_t'(RST_CTRL[CB_TRIG +: 2]);
      cfg_r.timeTrk <= RST_CTRL[CB_TTRK];
      cfg_r.pedalEn <= RST_CTRL[CB_PEDAL];
      cfg_r.mono    <= RST_CTRL[CB_MONO];
      cfg_r.modSel  <= RST_CTRL[CB_MODS];
      cfg_r.depth   <= RST_CTRL[CB_DEPTH +: 7];
    end else if (regWr) begin
      case (regAddr)
        OFS_TIME0: begin
          cfg_r.dly <= regWdata[FB0 +: 7];
          cfg_r.atk <= regWdata[FB1 +: 7];
          cfg_r.dcy <= regWdata[FB2 +: 7];
          cfg_r.sus <= regWdata[FB3 +: 7];
        end
        OFS_TIME1: begin
          cfg_r.sdec   <= regWdata[FB0 +: 7];
          cfg_r.rel    <= regWdata[FB1 +: 7];
          cfg_r.lvl    <= regWdata[FB2 +: 7];
          cfg_r.velAmt <= regWdata[FB3 +: 7];
        end
        OFS_CTRL: begin
          // four trigger modes, bit 0 free-run, bit 1 restart
          cfg_r.trig    <= meg_trig_t'(regWdata[CB_TRIG +: 2]);
          cfg_r.timeTrk <= regWdata[CB_TTRK];
          cfg_r.pedalEn <= regWdata[CB_PEDAL];
          cfg_r.mono    <= regWdata[CB_MONO];
          cfg_r.modSel  <= regWdata[CB_MODS];
          cfg_r.depth   <= regWdata[CB_DEPTH +: 7];
        end
        default: ;
      endcase
    end
  end

  // read data stands in the cycle after the strobe; unmapped reads 0
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      regRdata_r <= 32'h0000_0000;
    end else if (regRd) begin
      regRdata_r <= 32'h0000_0000;
      case (regAddr)
        OFS_TIME0:
          regRdata_r <= {1'b0, cfg_r.sus, 1'b0, cfg_r.dcy,
                         1'b0, cfg_r.atk, 1'b0, cfg_r.dly};
        OFS_TIME1:
          regRdata_r <= {1'b0, cfg_r.velAmt, 1'b0, cfg_r.lvl,
                         1'b0, cfg_r.rel, 1'b0, cfg_r.sdec};
        OFS_CTRL:
          regRdata_r <= {17'h0_0000, cfg_r.depth, 2'h0, cfg_r.modSel,
                         cfg_r.mono, cfg_r.pedalEn, cfg_r.timeTrk,
                         cfg_r.trig};
        OFS_STAT:
          regRdata_r <= {9'h000, envOut_r, 1'b0, level_r,
                         5'h00, stage_r};
        default: regRdata_r <= 32'h0000_0000;
      endcase
    end else begin
      regRdata_r <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // key and pedal tracking
  // ---------------------------------------------------------------
  logic keyHeld_r;
  logic pedalPrev_r;
  logic freeRun;
  logic restartMd;
  logic holdDly;
  logic pedHeld;
  logic keyGate;
  logic relKey;
  logic pedalFall;
  logic takeNote;
  logic evAny;

  // a note-on in the same cycle as a note-off wins
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      keyHeld_r <= 1'b0;
    end else if (noteIn.on) begin
      keyHeld_r <= 1'b1;
    end else if (noteIn.off) begin
      keyHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pedalPrev_r <= 1'b0;
    end else begin
      pedalPrev_r <= pedal;
    end
  end

  // hold delay forces free-run without touching cfg_r.trig
  assign holdDly   = cfg_r.dly > LVL_MAX;
  assign freeRun   = cfg_r.trig[0] | holdDly;
  assign restartMd = cfg_r.trig[1];
  // pedal only counts when pedal handling is on
  assign pedHeld   = cfg_r.pedalEn & pedal;
  assign keyGate   = keyHeld_r | pedHeld;
  // free-run ignores a release part way through
  assign relKey    = noteIn.off & keyHeld_r & ~noteIn.on & ~freeRun;
  assign pedalFall = cfg_r.pedalEn & pedalPrev_r & ~pedal & ~keyHeld_r
                   & ~freeRun;
  // mono legato notes retrigger only in restart modes
  assign takeNote  = noteIn.on & ~(cfg_r.mono & noteIn.legato & ~restartMd);
  assign evAny     = noteIn.on | noteIn.off | pedalFall;

  // ---------------------------------------------------------------
  // stage step timer
  // ---------------------------------------------------------------
  logic [27:0] curPer;
  logic [27:0] tmr_r;
  logic        tick;

  // square law table: monotonic, 0 gives 0
  function automatic logic [27:0] stepPer(input logic [6:0] v,
                                          input logic       trk,
                                          input logic [6:0] key);
    logic [27:0] base;
    logic [7:0]  d;
    logic [7:0]  f;
    logic [35:0] prod;
    base = 28'(v * v * 28'(TICK_CYC));
    d    = 8'(key) - 8'(KEY_CENTER);
    f    = 8'h40;
    // linear fit of 2^(-d/24), factor 64 = 1.0
    if (trk) begin
      if (!d[7]) begin
        if (d > TRK_SPAN) d = TRK_SPAN;
        // widen first: 24 keys times 43 overflows eight bits
        f = 8'h40 - 8'((16'(d) * 16'd43) >> 5);
      end else begin
        d = 8'h00 - d;
        if (d > TRK_SPAN) d = TRK_SPAN;
        f = 8'h40 + 8'((16'(d) * 16'd171) >> 6);
      end
    end
    prod    = 36'(base) * 36'(f);
    stepPer = 28'(prod >> 6);
  endfunction

  // attack and delay never take key tracking
  always_comb begin
    case (stage_r)
      ST_DELAY:   curPer = stepPer(cfg_r.dly, 1'b0, noteIn.key);
      ST_ATTACK:  curPer = stepPer(cfg_r.atk, 1'b0, noteIn.key);
      ST_DECAY:   curPer = stepPer(cfg_r.dcy, cfg_r.timeTrk, noteIn.key);
      ST_SUSTAIN: curPer = stepPer(cfg_r.sdec, cfg_r.timeTrk, noteIn.key);
      ST_RELEASE: curPer = stepPer(cfg_r.rel, cfg_r.timeTrk, noteIn.key);
      default:    curPer = 28'h000_0001;
    endcase
  end

  // restart the count on every stage change so a stage gets full steps
  assign tick = (tmr_r + 28'h000_0001 >= curPer);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tmr_r       <= 28'h000_0000;
      stagePrev_r <= ST_IDLE;
    end else begin
      stagePrev_r <= stage_r;
      if (tick || stage_r != stagePrev_r) begin
        tmr_r <= 28'h000_0000;
      end else begin
        tmr_r <= tmr_r + 28'h000_0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // stage machine
  // ---------------------------------------------------------------
  logic [6:0] dlyCnt_r;
  logic       quickEnv;

  assign quickEnv = (cfg_r.dly == 7'h00) && (cfg_r.atk == 7'h00)
                 && (cfg_r.dcy == 7'h00 || cfg_r.sus == LVL_MAX);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      stage_r  <= ST_IDLE;
      level_r  <= 7'h00;
      dlyCnt_r <= 7'h00;
    end else if (takeNote) begin
      if (restartMd || stage_r == ST_IDLE) begin
        stage_r  <= ST_DELAY;
        level_r  <= 7'h00;
        dlyCnt_r <= 7'h00;
      end else if (stage_r == ST_RELEASE) begin
        stage_r <= ST_ATTACK;        // continue from current level
      end
    end else if (relKey) begin
      if (pedHeld) begin
        if (quickEnv) begin
          stage_r <= ST_SUSTAIN;
        end else if (stage_r == ST_ATTACK) begin
          stage_r <= ST_SUSTAIN;
        end else if (stage_r == ST_DELAY) begin
          stage_r <= ST_IDLE;        // output stays at zero
          level_r <= 7'h00;
        end
      end else if (stage_r != ST_IDLE) begin
        stage_r <= ST_RELEASE;
      end
    end else if (pedalFall) begin
      // pedal was the only thing holding the note
      if (stage_r != ST_IDLE) begin
        stage_r <= ST_RELEASE;
      end
    end else begin
      case (stage_r)
        ST_DELAY: begin
          if (holdDly) begin
            if (!keyHeld_r) stage_r <= ST_ATTACK;
          end else if (dlyCnt_r >= cfg_r.dly) begin
            stage_r <= ST_ATTACK;
          end else if (tick) begin
            dlyCnt_r <= dlyCnt_r + 7'h01;
          end
        end
        ST_ATTACK: begin
          if (level_r >= LVL_MAX) begin
            stage_r <= (cfg_r.sus >= LVL_MAX) ? ST_SUSTAIN : ST_DECAY;
          end else if (cfg_r.atk == 7'h00) begin
            level_r <= LVL_MAX;
          end else if (tick) begin
            level_r <= level_r + 7'h01;
          end
        end
        ST_DECAY: begin
          if (level_r <= cfg_r.sus) begin
            stage_r <= ST_SUSTAIN;
          end else if (cfg_r.dcy == 7'h00) begin
            level_r <= cfg_r.sus;
          end else if (tick) begin
            level_r <= level_r - 7'h01;
          end
        end
        ST_SUSTAIN: begin
          if (freeRun && !keyGate) begin
            stage_r <= ST_RELEASE;
          end else if (cfg_r.sdec >= LVL_MAX || level_r == 7'h00) begin
            level_r <= level_r;
          end else if (cfg_r.sdec == 7'h00) begin
            level_r <= 7'h00;
          end else if (tick) begin
            level_r <= level_r - 7'h01;
          end
        end
        ST_RELEASE: begin
          if (level_r == 7'h00) begin
            stage_r <= ST_IDLE;
          end else if (cfg_r.rel == 7'h00) begin
            level_r <= 7'h00;
          end else if (tick) begin
            level_r <= level_r - 7'h01;
          end
        end
        default: stage_r <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // output scaling
  // ---------------------------------------------------------------
  logic [13:0] velProd;
  logic [7:0]  lvlSum;
  logic [6:0]  effLvl;
  logic [22:0] outProd;
  logic [7:0]  outScl;

  // velocity part is velAmt*vel/128, so 0 adds nothing
  assign velProd = cfg_r.velAmt * noteIn.vel;
  assign lvlSum  = {1'b0, cfg_r.lvl} + {1'b0, velProd[13:7]};
  // saturate: the sum can reach 253 but output never passes 99
  assign effLvl  = (lvlSum > {1'b0, LVL_MAX}) ? LVL_MAX : lvlSum[6:0];
  // level 00 gives silence, 99 full scale
  assign outProd = 23'(level_r) * 23'(effLvl) * 23'(DIV99_MUL);
  assign outScl  = 8'(outProd >> DIV99_SH);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      envOut_r    <= 7'h00;
      filterOut_r <= 7'h00;
    end else begin
      envOut_r <= (outScl > {1'b0, LVL_MAX}) ? LVL_MAX : outScl[6:0];
      // filter path only when depth is set or routed as source
      if (cfg_r.depth != 7'h00 || cfg_r.modSel) begin
        filterOut_r <= envOut_r;
      end else begin
        filterOut_r <= 7'h00;
      end
    end
  end

  assign regRdata  = regRdata_r;
  assign envOut    = envOut_r;
  assign filterOut = filterOut_r;
  assign envStage  = stage_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  outCap_a: assert property (envOut_r <= LVL_MAX)
    else $error("envelope output above 99");
  velNone_a: assert property (
    cfg_r.velAmt == 7'h00 |-> effLvl == cfg_r.lvl)
    else $error("velocity changed level at zero amount");
  filtGate_a: assert property (
    cfg_r.depth == 7'h00 && !cfg_r.modSel |=> filterOut_r == 7'h00)
    else $error("filter driven while unrouted");
  atkZero_a: assert property (
    stage_r == ST_ATTACK && cfg_r.atk == 7'h00 && level_r != LVL_MAX
    && !evAny |=> level_r == LVL_MAX)
    else $error("zero attack not instant");
  susSkip_a: assert property (
    stage_r == ST_ATTACK && level_r == LVL_MAX && cfg_r.sus == LVL_MAX
    && !evAny |=> stage_r == ST_SUSTAIN)
    else $error("decay not skipped at sustain 99");
  dlyZero_a: assert property (
    stage_r == ST_DELAY && cfg_r.dly == 7'h00 && !evAny
    |=> stage_r == ST_ATTACK)
    else $error("zero delay did not start attack");
  holdWait_a: assert property (
    stage_r == ST_DELAY && holdDly && keyHeld_r && !evAny
    |=> stage_r == ST_DELAY && level_r == 7'h00)
    else $error("hold delay left early");
  sdZero_a: assert property (
    stage_r == ST_SUSTAIN && cfg_r.sdec == 7'h00 && keyGate && !evAny
    |=> level_r == 7'h00)
    else $error("zero sustain decay did not drop");
  normRel_a: assert property (
    relKey && !pedHeld && stage_r != ST_IDLE && !takeNote
    |=> stage_r == ST_RELEASE)
    else $error("release not immediate");
  restart_a: assert property (
    takeNote && restartMd |=> stage_r == ST_DELAY && level_r == 7'h00)
    else $error("restart mode did not restart");

  reachSus_c: cover property (stage_r == ST_DECAY ##1 stage_r == ST_SUSTAIN);
  relIdle_c:  cover property (stage_r == ST_RELEASE ##1 stage_r == ST_IDLE);
  holdRun_c:  cover property (stage_r == ST_DELAY && holdDly
                              ##1 stage_r == ST_ATTACK);
  pedJump_c:  cover property (relKey && pedHeld && stage_r == ST_ATTACK);

endmodule

`default_nettype wire

// [verification/meg_note_src.sv]
// keyboard and pedal model that turns key levels into note pulses
`timescale 1ns/100ps
`default_nettype none

module meg_note_src
  import meg_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       keyDown,
  input  wire logic       pedalDown,
  input  wire logic       legatoIn,
  input  wire logic [6:0] keyNum,
  input  wire logic [6:0] velIn,
  output var  meg_note_t  noteOut,
  output var  logic       pedalOut
);

  logic prevDown_r;

  // -------------------------------------------------------------
  // key edges to pulses
  // -------------------------------------------------------------
  // key, velocity and legato are registered from their inputs every cycle,
  // not held while a note sounds; only the edges of the key level become pulses
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      prevDown_r <= 1'b0;
      noteOut    <= '0;
      pedalOut   <= 1'b0;
    end else begin
      prevDown_r     <= keyDown;
      noteOut.on     <= keyDown & ~prevDown_r;
      noteOut.off    <= ~keyDown & prevDown_r;
      noteOut.legato <= legatoIn;
      noteOut.key    <= keyNum;
      noteOut.vel    <= velIn;
      pedalOut       <= pedalDown;
    end
  end

endmodule

`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the envelope generator
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import meg_pkg::*;
;

  logic        core_clk, rst_b, regWr, regRd, kDown, pDown, leg, pedal;
  logic [3:0]  regAddr;
  logic [31:0] regWdata, regRdata;
  logic [6:0]  kVel, kNum, envOut, filterOut;
  meg_note_t   noteIn;
  meg_stage_t  envStage;
  int          err_total, check_count;
  // last entry leaves full output standing for the routing checks
  logic [31:0] lvW [5] = '{32'h0028_0063, 32'h6300_0063, 32'h2d46_0063,
                          32'h0000_0063, 32'h0063_0063};
  logic [6:0]  lvV [5] = '{7'h00, 7'h40, 7'h7f, 7'h7f, 7'h00};
  logic [6:0]  lvE [5] = '{7'h28, 7'h31, 7'h63, 7'h00, 7'h63};
  logic [31:0] trC [4] = '{32'h0, 32'h2, 32'h10, 32'h12};
  meg_stage_t  trE [4] = '{ST_ATTACK, ST_DELAY, ST_RELEASE, ST_DELAY};

  // one cycle per step unit keeps the slow stages within a short run
  meg_env #(.TICK_CYC(1)) meg_env_inst (
    .core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .noteIn(noteIn), .pedal(pedal),
    .envOut(envOut), .filterOut(filterOut), .envStage(envStage));

  meg_note_src meg_note_src_inst (
    .core_clk(core_clk), .rst_b(rst_b), .keyDown(kDown),
    .pedalDown(pDown), .legatoIn(leg), .keyNum(kNum), .velIn(kVel),
    .noteOut(noteIn), .pedalOut(pedal));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // -------------------------------------------------------------
  // access tasks
  // -------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge core_clk);
    regWr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge core_clk);
    regRd   <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic cfg(input logic [31:0] t0, t1, c);
    wr(OFS_TIME0, t0);
    wr(OFS_TIME1, t1);
    wr(OFS_CTRL, c);
  endtask

  task automatic keyTo(input logic d);
    @(posedge core_clk);
    kDown <= d;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // bounded wait for a stage; running out ends the run
  task automatic waitSt(input meg_stage_t st);
    int n;
    for (n = 0; n < 4000; n++) begin
      @(posedge core_clk);
      #1;
      if (envStage === st) return;
    end
    chk("stage wait", 32'(envStage), 32'(st));
    close_out();
  endtask

  task automatic rstPulse();
    @(posedge core_clk);
    rst_b <= 1'b0;
    kDown <= 1'b0;
    pDown <= 1'b0;
    leg   <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
  endtask

  // note off with the pedal down, in a given stage and pedal setting
  task automatic pedalCase(input logic [31:0] c, t0,
                           input meg_stage_t w, e);
    rstPulse();
    cfg(t0, 32'h0063_0563, c);
    pDown <= 1'b1;
    keyTo(1'b1);
    waitSt(w);
    keyTo(1'b0);
    waitSt(e);
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    logic [31:0] d;
    rst_b = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 4'h0;
    regWdata = 32'h0; kDown = 1'b0; pDown = 1'b0; leg = 1'b0;
    kVel = 7'h7f; err_total = 0; check_count = 0;
    kNum = 7'h3c;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(OFS_TIME0, d); chk("time0 reset", d, RST_TIME0);
    rd(OFS_TIME1, d); chk("time1 reset", d, RST_TIME1);
    rd(OFS_CTRL, d);  chk("ctrl reset", d, RST_CTRL);
    wr(OFS_STAT, 32'hffff_ffff);
    rd(OFS_STAT, d);  chk("status", d, 32'h0);
    rd(4'h1, d);      chk("unmapped", d, 32'h0);
    wr(OFS_TIME0, 32'hff7f_80aa);
    rd(OFS_TIME0, d); chk("time0 fields", d, 32'h7f7f_002a);
    $display("test registers done");
    // level, velocity amount and saturation table
    for (int i = 0; i < 5; i++) begin
      rstPulse();
      cfg(RST_TIME0, lvW[i], 32'h0);
      kVel <= lvV[i];
      keyTo(1'b1);
      waitSt(ST_SUSTAIN);
      settle(3);
      chk("level", 32'(envOut), 32'(lvE[i]));
    end
    $display("test levels done");
    // filter routing follows depth or modulation source
    chk("filter unrouted", 32'(filterOut), 32'h0);
    wr(OFS_CTRL, 32'h0000_0100);
    settle(3);
    chk("filter depth", 32'(filterOut), 32'h63);
    rstPulse();
    cfg(RST_TIME0, RST_TIME1, 32'h20);
    keyTo(1'b1);
    waitSt(ST_SUSTAIN);
    settle(3);
    chk("filter mod", 32'(filterOut), 32'h63);
    keyTo(1'b0);
    waitSt(ST_RELEASE);
    waitSt(ST_IDLE);
    settle(2);
    chk("released", 32'(envOut), 32'h0);
    $display("test routing done");
    // new note after release: continue, restart, mono legato
    for (int i = 0; i < 4; i++) begin
      rstPulse();
      cfg(32'h6300_0503, 32'h0063_0563, trC[i]);
      keyTo(1'b1);
      waitSt(ST_SUSTAIN);
      keyTo(1'b0);
      waitSt(ST_RELEASE);
      // let release fall a little so a continued attack is visible
      settle(60);
      keyTo(1'b1);
      leg <= trC[i][4];
      settle(8);
      chk("retrigger", 32'(envStage), 32'(trE[i]));
    end
    $display("test triggers done");
    // run-to-completion ignores an early release
    for (int m = 1; m < 4; m += 2) begin
      rstPulse();
      cfg(32'h6300_0500, RST_TIME1, 32'(m));
      keyTo(1'b1);
      waitSt(ST_ATTACK);
      keyTo(1'b0);
      settle(8);
      chk("free run", 32'(envStage), 32'(ST_ATTACK));
    end
    // hold delay waits for the key, stored mode untouched
    rstPulse();
    cfg(32'h6300_0264, RST_TIME1, 32'h0);
    keyTo(1'b1);
    settle(40);
    chk("hold", 32'(envStage), 32'(ST_DELAY));
    keyTo(1'b0);
    waitSt(ST_ATTACK);
    rd(OFS_CTRL, d);
    chk("mode kept", d, 32'h0);
    $display("test delay done");
    // pedal handling on and off
    pedalCase(32'h8, 32'h6300_0500, ST_ATTACK, ST_SUSTAIN);
    @(posedge core_clk);
    pDown <= 1'b0;
    waitSt(ST_RELEASE);
    pedalCase(32'h0, 32'h6300_0500, ST_ATTACK, ST_RELEASE);
    pedalCase(32'h8, 32'h6300_0503, ST_DELAY, ST_IDLE);
    settle(3);
    chk("pedal delay", 32'(envOut), 32'h0);
    $display("test pedal done");
    // zero sustain-decay drops at once
    rstPulse();
    cfg(RST_TIME0, 32'h0063_0000, 32'h0);
    keyTo(1'b1);
    waitSt(ST_SUSTAIN);
    settle(4);
    chk("sustain drop", 32'(envOut), 32'h0);
    $display("test sustain done");
    // two octaves up halves release but leaves attack alone
    rstPulse();
    kNum <= 7'h54;
    cfg(32'h6300_0400, 32'h0063_0463, 32'h4);
    keyTo(1'b1);
    settle(900);
    chk("track attack", 32'(envStage), 32'(ST_ATTACK));
    waitSt(ST_SUSTAIN);
    keyTo(1'b0);
    settle(900);
    chk("track release", 32'(envStage), 32'(ST_IDLE));
    $display("test tracking done");
    close_out();
  end

endmodule

`default_nettype wire
